/* File: rtl/exc_check_pkg.sv */
// Shared constants and state type of the exception check sequencer.
// Assumes one core clock; all vectors are 8-bit interrupt numbers.
package exc_check_pkg;
    localparam int       VEC_W           = 8;
    localparam int       LEN_W           = 5;
    localparam int       ADDR_W          = 32;
    localparam int       MAX_INSTR_BYTES = 15;
    localparam logic [7:0] VEC_NONE      = 8'h00;
    localparam logic [7:0] VEC_DEBUG     = 8'h01;
    localparam logic [7:0] VEC_NMI       = 8'h02;
    localparam logic [7:0] VEC_INV_OP    = 8'h06;
    localparam logic [7:0] VEC_NO_COPROC = 8'h07;
    localparam logic [7:0] VEC_DOUBLE    = 8'h08;
    localparam logic [7:0] VEC_BAD_TASK_STATE = 8'h0A;
    localparam logic [7:0] VEC_NOT_PRES  = 8'h0B;
    localparam logic [7:0] VEC_STACK     = 8'h0C;
    localparam logic [7:0] VEC_GEN_PROT  = 8'h0D;
    localparam logic [7:0] VEC_PAGE      = 8'h0E;
    localparam logic [7:0] VEC_FP_ERROR  = 8'h10;
    localparam logic [31:0] PTR_RESET    = 32'h0000_0000;

    typedef enum logic [8:0] {
        S_IDLE      = 9'h001,
        S_DBG_TRAP  = 9'h002,
        S_DBG_FAULT = 9'h004,
        S_EXTERNAL  = 9'h008,
        S_FETCH_SEG = 9'h010,
        S_FETCH_PG  = 9'h020,
        S_DECODE    = 9'h040,
        S_MEMREF    = 9'h080,
        S_HANDLER   = 9'h100
    } chk_state_t;
endpackage

/* File: rtl/check_if.sv */
// Carrier between the sequencer and its decode and escalation helpers.
// Assumes all signals are combinational within the core clock cycle.
`timescale 1ns/1ps
interface check_if;
    import exc_check_pkg::*;
    logic             op_wait;
    logic             op_fp;
    logic             op_nowait_ctl;
    logic             illegal_op;
    logic             prot_only;
    logic             real_or_v86;
    logic [LEN_W-1:0] instr_len;
    logic             priv_viol;
    logic             task_switched_flag;
    logic             monitor_coproc_flag;
    logic             emulate_fp_flag;
    logic             fp_err;
    logic             dec_hit;
    logic [VEC_W-1:0] dec_vec;
    logic [VEC_W-1:0] cur_vec;
    logic [VEC_W-1:0] fault_vec;
    logic             esc_double;
    logic [VEC_W-1:0] esc_vec;
    modport core (output op_wait, op_fp, op_nowait_ctl, illegal_op, prot_only,
                  real_or_v86, instr_len, priv_viol, task_switched_flag,
                  monitor_coproc_flag, emulate_fp_flag, fp_err,
                  cur_vec, fault_vec,
                  input dec_hit, dec_vec, esc_double, esc_vec);
    modport dec  (input op_wait, op_fp, op_nowait_ctl, illegal_op, prot_only,
                  real_or_v86, instr_len, priv_viol, task_switched_flag,
                  monitor_coproc_flag, emulate_fp_flag, fp_err,
                  output dec_hit, dec_vec);
    modport esc  (input cur_vec, fault_vec, output esc_double, esc_vec);
endinterface

/* File: rtl/decode_fault_eval.sv */
// Decode, coprocessor availability and numeric error checks, in order.
// Assumes opcode class and control flags are stable during the check.
`timescale 1ns/1ps
module decode_fault_eval
    import exc_check_pkg::*;
(
    check_if.dec c
);
    wire f6  = c.illegal_op | (c.prot_only & c.real_or_v86);
    wire f13 = (c.instr_len > LEN_W'(MAX_INSTR_BYTES)) | c.priv_viol;
    wire w7  = c.op_wait & c.task_switched_flag & c.monitor_coproc_flag;
    wire fp7 = c.op_fp & (c.emulate_fp_flag | c.task_switched_flag);
    // No-wait control forms never take the error vector
    wire e16 = (c.op_fp | c.op_wait) & c.fp_err & ~c.op_nowait_ctl;

    assign c.dec_hit = f6 | f13 | w7 | fp7 | e16;
    assign c.dec_vec = f6        ? VEC_INV_OP :
                       f13       ? VEC_GEN_PROT :
                       (w7|fp7)  ? VEC_NO_COPROC :
                       e16       ? VEC_FP_ERROR : VEC_NONE;
endmodule // decode_fault_eval

/* File: rtl/double_fault_eval.sv */
// Escalation of a fault met while entering a handler.
// Assumes cur_vec holds the vector whose handler is being entered.
`timescale 1ns/1ps
module double_fault_eval
    import exc_check_pkg::*;
(
    check_if.esc e
);
    wire seg_class  = (e.cur_vec >= VEC_BAD_TASK_STATE) && (e.cur_vec <= VEC_GEN_PROT);
    wire page_class = (e.cur_vec == VEC_PAGE);
    wire not_page   = (e.fault_vec != VEC_PAGE);

    assign e.esc_double = (seg_class | page_class) & not_page;
    assign e.esc_vec    = e.esc_double ? VEC_DOUBLE : e.fault_vec;
endmodule // double_fault_eval

/* File: rtl/exception_priority_checker.sv */
// Per-instruction exception and interrupt check sequencer.
// Assumes the core pulses CHECK_START at each boundary and reports
// fetch, decode and memory reference status on synchronous inputs.
`timescale 1ns/1ps
module exception_priority_checker
    import exc_check_pkg::*;
(
    input  wire logic              CLK,
    input  wire logic              RESET,
    input  wire logic              CHECK_START,
    input  wire logic              TRAP_SINGLE_STEP,
    input  wire logic              TRAP_DATA_BKPT,
    input  wire logic              FAULT_EXEC_BKPT,
    input  wire logic              NMI_REQUEST,
    input  wire logic              NMI_RETURN,
    input  wire logic              MASKABLE_REQUEST,
    input  wire logic              INT_ENABLE,
    input  wire logic              FETCH_SEG_FAULT,
    input  wire logic              FETCH_SEG_GP,
    input  wire logic              FETCH_PAGE_FAULT,
    input  wire logic              ILLEGAL_OPCODE,
    input  wire logic              PROT_ONLY_OPCODE,
    input  wire logic              REAL_OR_V86_MODE,
    input  wire logic [LEN_W-1:0]  INSTR_LENGTH,
    input  wire logic              PRIV_VIOLATION,
    input  wire logic              OP_WAIT,
    input  wire logic              OP_FP,
    input  wire logic              OP_FP_NOWAIT_CTL,
    input  wire logic              TASK_SWITCHED_FLAG,
    input  wire logic              MONITOR_COPROC_FLAG,
    input  wire logic              EMULATE_FP_FLAG,
    input  wire logic              FP_ERROR_STATUS,
    input  wire logic              FP_UNMASKED_EXC,
    input  wire logic              FP_EXC_CLEAR,
    input  wire logic [ADDR_W-1:0] FP_FAULT_INSTR_ADDR,
    input  wire logic [ADDR_W-1:0] FP_FAULT_OPND_ADDR,
    input  wire logic              MEM_REF_VALID,
    input  wire logic              MEM_SEG_FAULT,
    input  wire logic [VEC_W-1:0]  MEM_SEG_VEC,
    input  wire logic              MEM_FP_LIMIT,
    input  wire logic              MEM_PAGE_FAULT,
    input  wire logic              EXEC_DONE,
    input  wire logic              TASK_STATE_PARTIAL_SWITCH,
    input  wire logic              ENTRY_FAULT,
    input  wire logic [VEC_W-1:0]  ENTRY_FAULT_VEC,
    input  wire logic              ENTRY_DONE,
    output logic                   EXC_VALID,
    output logic [VEC_W-1:0]       EXC_VECTOR,
    output logic                   EXC_ACK_CYCLE,
    output logic                   EXC_RESTARTABLE,
    output logic                   INSTR_DONE,
    output logic                   CHECK_BUSY,
    output logic                   NMI_BLOCKED,
    output logic                   FP_EXC_PENDING,
    output logic [ADDR_W-1:0]      FP_INSTR_PTR,
    output logic [ADDR_W-1:0]      FP_OPND_PTR
);
    check_if c ();

    chk_state_t        st_q;
    chk_state_t        st_d;
    logic              exc_valid_q;
    logic [VEC_W-1:0]  exc_vec_q;
    logic              ack_q;
    logic              restart_q;
    logic              done_q;
    logic [VEC_W-1:0]  cur_vec_q;
    logic              nmi_pend_q;
    logic              nmi_req_q;
    logic              nmi_block_q;
    logic              fp_pend_q;
    logic [ADDR_W-1:0] fp_iptr_q;
    logic [ADDR_W-1:0] fp_optr_q;
    logic              raise;
    logic [VEC_W-1:0]  raise_vec;
    logic              raise_ack;

    assign c.op_wait       = OP_WAIT;
    assign c.op_fp         = OP_FP;
    assign c.op_nowait_ctl = OP_FP_NOWAIT_CTL;
    assign c.illegal_op    = ILLEGAL_OPCODE;
    assign c.prot_only     = PROT_ONLY_OPCODE;
    assign c.real_or_v86   = REAL_OR_V86_MODE;
    assign c.instr_len     = INSTR_LENGTH;
    assign c.priv_viol     = PRIV_VIOLATION;
    assign c.task_switched_flag  = TASK_SWITCHED_FLAG;
    assign c.monitor_coproc_flag = MONITOR_COPROC_FLAG;
    assign c.emulate_fp_flag     = EMULATE_FP_FLAG;
    // Deferred unmasked numeric exception surfaces here only
    assign c.fp_err        = FP_ERROR_STATUS | fp_pend_q;
    assign c.cur_vec       = cur_vec_q;
    assign c.fault_vec     = ENTRY_FAULT_VEC;

    decode_fault_eval u_dec (
        .c (c.dec)
    );

    double_fault_eval u_esc (
        .e (c.esc)
    );

    // Check hits per step of the sequence
    wire dbg_trap  = TRAP_SINGLE_STEP | TRAP_DATA_BKPT;
    wire nmi_go    = nmi_pend_q & ~nmi_block_q;
    wire mask_go   = MASKABLE_REQUEST & INT_ENABLE;
    wire ext_hit   = nmi_go | mask_go;
    wire [VEC_W-1:0] fetch_seg_vec = FETCH_SEG_GP ? VEC_GEN_PROT : VEC_NOT_PRES;
    wire seg_hit   = MEM_REF_VALID & (MEM_SEG_FAULT | MEM_FP_LIMIT);
    // Limit overrun of a numeric operand reports as general protection
    wire [VEC_W-1:0] mem_seg_vec = MEM_FP_LIMIT ? VEC_GEN_PROT : MEM_SEG_VEC;
    wire page_hit  = MEM_REF_VALID & MEM_PAGE_FAULT;
    wire ref_fault = seg_hit | page_hit;
    wire in_idle   = (st_q == S_IDLE);
    wire in_hand   = (st_q == S_HANDLER);

    always_comb
    begin
        st_d      = st_q;
        raise     = 1'b0;
        raise_vec = VEC_NONE;
        raise_ack = 1'b0;
        unique case (st_q)
            S_IDLE:
            begin
                // A retry restarts at the first check
                if (CHECK_START)
                    st_d = S_DBG_TRAP;
            end
            S_DBG_TRAP:
            begin
                raise     = dbg_trap;
                raise_vec = VEC_DEBUG;
                st_d      = dbg_trap ? S_HANDLER : S_DBG_FAULT;
            end
            S_DBG_FAULT:
            begin
                raise     = FAULT_EXEC_BKPT;
                raise_vec = VEC_DEBUG;
                st_d      = FAULT_EXEC_BKPT ? S_HANDLER : S_EXTERNAL;
            end
            S_EXTERNAL:
            begin
                raise     = ext_hit;
                // Maskable vector comes later from the acknowledge cycle
                raise_vec = nmi_go ? VEC_NMI : VEC_NONE;
                raise_ack = ~nmi_go & mask_go;
                st_d      = ext_hit ? S_HANDLER : S_FETCH_SEG;
            end
            S_FETCH_SEG:
            begin
                raise     = FETCH_SEG_FAULT;
                raise_vec = fetch_seg_vec;
                st_d      = FETCH_SEG_FAULT ? S_HANDLER : S_FETCH_PG;
            end
            S_FETCH_PG:
            begin
                raise     = FETCH_PAGE_FAULT;
                raise_vec = VEC_PAGE;
                st_d      = FETCH_PAGE_FAULT ? S_HANDLER : S_DECODE;
            end
            S_DECODE:
            begin
                raise     = c.dec_hit;
                raise_vec = c.dec_vec;
                st_d      = c.dec_hit ? S_HANDLER : S_MEMREF;
            end
            S_MEMREF:
            begin
                raise     = ref_fault;
                raise_vec = seg_hit ? mem_seg_vec : VEC_PAGE;
                if (ref_fault)
                    st_d = S_HANDLER;
                else if (EXEC_DONE)
                    st_d = S_IDLE;
            end
            S_HANDLER:
            begin
                // Entry faults raise esc_vec, a double fault only for a non-page fault on a vector 0A-0E entry; everything else is held off
                raise     = ENTRY_FAULT;
                raise_vec = c.esc_vec;
                if (ENTRY_DONE && !ENTRY_FAULT)
                    st_d = S_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
            st_q <= S_IDLE;
        else
            st_q <= st_d;
    end

    // One registered exception report per raise
    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
        begin
            exc_valid_q <= 1'b0;
            exc_vec_q   <= VEC_NONE;
            ack_q       <= 1'b0;
            restart_q   <= 1'b1;
        end
        else
        begin
            exc_valid_q <= raise;
            if (raise)
            begin
                exc_vec_q <= raise_vec;
                ack_q     <= raise_ack;
                restart_q <= ~TASK_STATE_PARTIAL_SWITCH;
            end
        end
    end

    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
            cur_vec_q <= VEC_NONE;
        else if (raise)
            cur_vec_q <= raise_vec;
    end

    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
            done_q <= 1'b0;
        else
            done_q <= (st_q == S_MEMREF) & EXEC_DONE & ~ref_fault;
    end

    // Request edge is latched; a new edge beats the take in the same cycle
    wire nmi_edge  = NMI_REQUEST & ~nmi_req_q;
    wire nmi_taken = (st_q == S_EXTERNAL) & nmi_go;

    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
        begin
            nmi_req_q   <= 1'b0;
            nmi_pend_q  <= 1'b0;
            nmi_block_q <= 1'b0;
        end
        else
        begin
            nmi_req_q   <= NMI_REQUEST;
            nmi_pend_q  <= nmi_edge | (nmi_pend_q & ~nmi_taken);
            nmi_block_q <= nmi_taken | (nmi_block_q & ~NMI_RETURN);
        end
    end

    // Pointers capture the faulting numeric instruction and operand
    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
        begin
            fp_pend_q <= 1'b0;
            fp_iptr_q <= PTR_RESET;
            fp_optr_q <= PTR_RESET;
        end
        else
        begin
            fp_pend_q <= FP_UNMASKED_EXC | (fp_pend_q & ~FP_EXC_CLEAR);
            if (FP_UNMASKED_EXC)
            begin
                fp_iptr_q <= FP_FAULT_INSTR_ADDR;
                fp_optr_q <= FP_FAULT_OPND_ADDR;
            end
        end
    end

    assign EXC_VALID       = exc_valid_q;
    assign EXC_VECTOR      = exc_vec_q;
    assign EXC_ACK_CYCLE   = ack_q;
    assign EXC_RESTARTABLE = restart_q;
    assign INSTR_DONE      = done_q;
    assign CHECK_BUSY      = ~in_idle;
    assign NMI_BLOCKED     = nmi_block_q;
    assign FP_EXC_PENDING  = fp_pend_q;
    assign FP_INSTR_PTR    = fp_iptr_q;
    assign FP_OPND_PTR     = fp_optr_q;

    default clocking cb @(posedge CLK); endclocking
    default disable iff (RESET);

    a_start_order: assert property (in_idle && CHECK_START |=> st_q == S_DBG_TRAP)
        else $error("check sequence did not start with debug traps");
    a_single_raise: assert property (exc_valid_q |-> in_hand)
        else $error("exception reported outside handler entry");
    a_trap_vector: assert property (st_q == S_DBG_TRAP && dbg_trap |=>
        exc_valid_q && exc_vec_q == VEC_DEBUG)
        else $error("debug trap not reported as vector 1");
    a_nmi_first: assert property (st_q == S_EXTERNAL && nmi_go && mask_go |=>
        exc_vec_q == VEC_NMI && !ack_q)
        else $error("maskable request beat non-maskable");
    a_nmi_no_ack: assert property (exc_valid_q && exc_vec_q == VEC_NMI |-> !ack_q)
        else $error("non-maskable entry asked for acknowledge");
    a_fetch_seg: assert property (st_q == S_FETCH_SEG && FETCH_SEG_FAULT |=>
        exc_valid_q && (exc_vec_q == VEC_NOT_PRES || exc_vec_q == VEC_GEN_PROT))
        else $error("fetch segment fault vector wrong");
    a_wait_coproc: assert property (st_q == S_DECODE && OP_WAIT &&
        TASK_SWITCHED_FLAG && MONITOR_COPROC_FLAG && !ILLEGAL_OPCODE && !PRIV_VIOLATION
        && !(PROT_ONLY_OPCODE && REAL_OR_V86_MODE) && INSTR_LENGTH <= LEN_W'(MAX_INSTR_BYTES)
        |=> exc_vec_q == VEC_NO_COPROC)
        else $error("wait with task switched not vector 7");
    a_nowait_no16: assert property (st_q == S_DECODE && OP_FP_NOWAIT_CTL |=>
        !(exc_valid_q && exc_vec_q == VEC_FP_ERROR))
        else $error("no-wait control form raised vector 16");
    a_seg_before_pg: assert property (st_q == S_MEMREF && seg_hit && page_hit |=>
        exc_vec_q != VEC_PAGE)
        else $error("page fault taken before segment fault");
    a_double_esc: assert property (in_hand && ENTRY_FAULT &&
        ENTRY_FAULT_VEC != VEC_PAGE && cur_vec_q >= VEC_BAD_TASK_STATE &&
        cur_vec_q <= VEC_PAGE |=> exc_vec_q == VEC_DOUBLE)
        else $error("entry fault not escalated to double fault");
    a_restart_flag: assert property (raise |=>
        EXC_RESTARTABLE == !$past(TASK_STATE_PARTIAL_SWITCH))
        else $error("restartable flag wrong");

    c_nmi_taken:   cover property (exc_valid_q && exc_vec_q == VEC_NMI);
    c_double:      cover property (exc_valid_q && exc_vec_q == VEC_DOUBLE);
    c_fp_deferred: cover property (fp_pend_q && exc_valid_q && exc_vec_q == VEC_FP_ERROR);
    c_clean_instr: cover property (done_q);
endmodule // exception_priority_checker

/* File: verification/irq_ctrl_model.sv */
// Behavioural interrupt controller facing the two request pins.
// Assumes bench commands change at the falling clock edge.
`timescale 1ns/1ps
module irq_ctrl_model (
    input  wire logic clk,
    input  wire logic reset,
    input  wire logic fire_nmi,
    input  wire logic raise_int,
    input  wire logic int_acked,
    output logic      nmi_req,
    output logic      int_req
);
    // Maskable request stays up until the core acknowledges it
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            {nmi_req, int_req} <= 2'h0;
        else
            {nmi_req, int_req} <= {fire_nmi, raise_int | (int_req & ~int_acked)};
    end
endmodule // irq_ctrl_model

/* File: verification/exception_priority_checker_tb.sv */
// Self-checking bench for the exception check sequencer, one call per case.
// Assumes the interrupt controller model drives both request pins.
`timescale 1ns/1ps
module exception_priority_checker_tb;
    import exc_check_pkg::*;
    logic CLK, RESET, CHECK_START, NMI_REQUEST, NMI_RETURN, MASKABLE_REQUEST, FP_UNMASKED_EXC;
    logic TRAP_SINGLE_STEP, TRAP_DATA_BKPT, FAULT_EXEC_BKPT, INT_ENABLE, FETCH_SEG_FAULT;
    logic FETCH_SEG_GP, FETCH_PAGE_FAULT, ILLEGAL_OPCODE, PROT_ONLY_OPCODE, REAL_OR_V86_MODE;
    logic PRIV_VIOLATION, OP_WAIT, OP_FP, OP_FP_NOWAIT_CTL, TASK_SWITCHED_FLAG, EMULATE_FP_FLAG;
    logic MONITOR_COPROC_FLAG, FP_ERROR_STATUS, FP_EXC_CLEAR, MEM_REF_VALID, MEM_SEG_FAULT;
    logic MEM_FP_LIMIT, MEM_PAGE_FAULT, EXEC_DONE, ENTRY_FAULT, ENTRY_DONE;
    logic TASK_STATE_PARTIAL_SWITCH;
    logic EXC_VALID, EXC_ACK_CYCLE, EXC_RESTARTABLE, INSTR_DONE, CHECK_BUSY, NMI_BLOCKED;
    logic FP_EXC_PENDING, fire_nmi, raise_int, mref;
    logic [LEN_W-1:0]  INSTR_LENGTH;
    logic [VEC_W-1:0]  MEM_SEG_VEC, ENTRY_FAULT_VEC, EXC_VECTOR;
    logic [ADDR_W-1:0] FP_FAULT_INSTR_ADDR, FP_FAULT_OPND_ADDR, FP_INSTR_PTR, FP_OPND_PTR;
    logic [24:0]       st;
    int                bad_count = 0;
    int                cmp_count = 0;
    // One scenario word sets the step flags; INSTR_LENGTH, MEM_SEG_VEC, MEM_REF_VALID and EXEC_DONE are driven apart
    assign {TASK_STATE_PARTIAL_SWITCH, fire_nmi, raise_int, mref, MEM_FP_LIMIT,
            TRAP_SINGLE_STEP, TRAP_DATA_BKPT, FAULT_EXEC_BKPT, INT_ENABLE, FETCH_SEG_FAULT,
            FETCH_SEG_GP, FETCH_PAGE_FAULT, ILLEGAL_OPCODE, PROT_ONLY_OPCODE, REAL_OR_V86_MODE,
            PRIV_VIOLATION, OP_WAIT, OP_FP, OP_FP_NOWAIT_CTL, TASK_SWITCHED_FLAG,
            MONITOR_COPROC_FLAG, EMULATE_FP_FLAG, FP_ERROR_STATUS, MEM_SEG_FAULT,
            MEM_PAGE_FAULT} = st;
    exception_priority_checker dut (.*);
    irq_ctrl_model intc (.clk(CLK), .reset(RESET), .fire_nmi(fire_nmi), .raise_int(raise_int),
        .int_acked(EXC_VALID & EXC_ACK_CYCLE), .nmi_req(NMI_REQUEST), .int_req(MASKABLE_REQUEST));
    initial
    begin
        CLK = 1'h0;
        forever #2 CLK = ~CLK;
    end
    task chk(input logic [71:0] got, input logic [71:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
        end
    endtask
    task wrap_up;
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic pulse(ref logic p);
        p = 1'h1;
        @(negedge CLK);
        p = 1'h0;
    endtask
    // Step inputs stay level until the outcome shows, then the handler is entered if an exception was reported
    task automatic run(input logic [24:0] s, input logic [7:0] ev, input int ek,
                       input logic [7:0] ef = 8'h00, input logic [7:0] e2 = 8'h00);
        int c;
        st = s;
        CHECK_START = 1'h1;
        @(negedge CLK);
        CHECK_START = 1'h0;
        for (c = 1; c < 40 && EXC_VALID !== 1'h1 && INSTR_DONE !== 1'h1; c++)
        begin
            MEM_REF_VALID = mref && c >= 6;
            EXEC_DONE = !mref && c >= 6;
            @(negedge CLK);
        end
        {MEM_REF_VALID, EXEC_DONE} = 2'h0;
        st = '0;
        chk(c < 40, 1);
        if (c == 40)
            wrap_up;
        if (ek < 0)
            chk({INSTR_DONE, CHECK_BUSY}, 2'h2);
        else
        begin
            chk({EXC_VALID, EXC_ACK_CYCLE, EXC_VECTOR}, {1'h1, ev === VEC_NONE, ev});
            if (ek > 0)
                chk(c, ek);
            if (ef !== 8'h00)
            begin
                ENTRY_FAULT_VEC = ef;
                pulse(ENTRY_FAULT);
                chk({EXC_VALID, EXC_VECTOR}, {1'h1, e2});
            end
            pulse(ENTRY_DONE);
            @(negedge CLK);
            chk({EXC_VALID, CHECK_BUSY}, 2'h0);
        end
        $display("test done at %0t", $time);
    endtask
    initial
    begin
        st = '0;
        {CHECK_START, NMI_RETURN, FP_UNMASKED_EXC, FP_EXC_CLEAR, MEM_REF_VALID} = '0;
        {EXEC_DONE, ENTRY_FAULT, ENTRY_DONE, MEM_SEG_VEC, ENTRY_FAULT_VEC} = '0;
        FP_FAULT_INSTR_ADDR = 32'h0000_1234;
        FP_FAULT_OPND_ADDR = 32'h0000_5678;
        INSTR_LENGTH = 5'h04;
        RESET = 1'h1;
        repeat (10) @(negedge CLK);
        RESET = 1'h0;
        chk({EXC_VALID, EXC_RESTARTABLE, CHECK_BUSY, NMI_BLOCKED, FP_EXC_PENDING, FP_INSTR_PTR,
             FP_OPND_PTR}, {5'h08, PTR_RESET, PTR_RESET});
        run(25'h0000000, VEC_NONE, -1);
        run(25'h0088000, VEC_DEBUG, 2);
        run(25'h0041000, VEC_DEBUG, 2);
        run(25'h0820000, VEC_DEBUG, 3);
        run(25'h0410000, VEC_NMI, 4);
        chk(NMI_BLOCKED, 1'h1);
        run(25'h0810000, VEC_NONE, 4);
        pulse(NMI_RETURN);
        run(25'h0000000, VEC_NMI, 4);
        pulse(NMI_RETURN);
        chk(NMI_BLOCKED, 1'h0);
        run(25'h000A000, VEC_NOT_PRES, 5);
        run(25'h000C000, VEC_GEN_PROT, 5);
        run(25'h0002000, VEC_PAGE, 6);
        INSTR_LENGTH = 5'h10;
        run(25'h0001000, VEC_INV_OP, 7);
        run(25'h0000000, VEC_GEN_PROT, 7);
        INSTR_LENGTH = 5'h0F;
        run(25'h0000800, VEC_NONE, -1);
        INSTR_LENGTH = 5'h04;
        run(25'h0000C00, VEC_INV_OP, 7);
        run(25'h0000200, VEC_GEN_PROT, 7);
        run(25'h0000130, VEC_NO_COPROC, 7);
        run(25'h0000120, VEC_NONE, -1);
        run(25'h0000088, VEC_NO_COPROC, 7);
        run(25'h00000A0, VEC_NO_COPROC, 7);
        run(25'h0000084, VEC_FP_ERROR, 7);
        run(25'h00000C4, VEC_NONE, -1);
        pulse(FP_UNMASKED_EXC);
        chk({FP_EXC_PENDING, FP_INSTR_PTR, FP_OPND_PTR}, {1'h1, 64'h0000_1234_0000_5678});
        run(25'h0000000, VEC_NONE, -1);
        run(25'h0000100, VEC_FP_ERROR, 7);
        pulse(FP_EXC_CLEAR);
        run(25'h0000100, VEC_NONE, -1);
        MEM_SEG_VEC = VEC_STACK;
        run(25'h0200003, VEC_STACK, 0);
        run(25'h0300001, VEC_GEN_PROT, 0);
        run(25'h1200001, VEC_PAGE, 0);
        chk(EXC_RESTARTABLE, 1'h0);
        run(25'h0200003, VEC_STACK, 0);
        chk(EXC_RESTARTABLE, 1'h1);
        run(25'h000C000, VEC_GEN_PROT, 5, VEC_NOT_PRES, VEC_DOUBLE);
        run(25'h000A000, VEC_NOT_PRES, 5, VEC_PAGE, VEC_PAGE);
        run(25'h0002000, VEC_PAGE, 6, VEC_PAGE, VEC_PAGE);
        run(25'h0002000, VEC_PAGE, 6, VEC_GEN_PROT, VEC_DOUBLE);
        wrap_up;
    end
endmodule // exception_priority_checker_tb
